//--- hw/snr_defs.svh
// Constants of the serial NOR read sequencer: opcodes, protocol codes and counts.
`ifndef SNR_DEFS_SVH
`define SNR_DEFS_SVH
// ----------------------------------------------------------------
// Read opcodes, three-byte address unless configured otherwise
// ----------------------------------------------------------------
`define SNR_OP_READ      8'h03
`define SNR_OP_FAST      8'h0b
`define SNR_OP_DOUT      8'h3b
`define SNR_OP_DIO       8'hbb
`define SNR_OP_QOUT      8'h6b
`define SNR_OP_QIO       8'heb
`define SNR_OP_DTR_FAST  8'h0d
`define SNR_OP_DTR_DOUT  8'h3d
`define SNR_OP_DTR_DIO   8'hbd
`define SNR_OP_DTR_QOUT  8'h6d
`define SNR_OP_DTR_QIO   8'hed
`define SNR_OP_QWORD     8'he7
// ----------------------------------------------------------------
// Read opcodes with a fixed four-byte address
// ----------------------------------------------------------------
`define SNR_OP4_READ     8'h13
`define SNR_OP4_FAST     8'h0c
`define SNR_OP4_DOUT     8'h3c
`define SNR_OP4_DIO      8'hbc
`define SNR_OP4_QOUT     8'h6c
`define SNR_OP4_QIO      8'hec
`define SNR_OP4_DTR_FAST 8'h0e
`define SNR_OP4_DTR_DIO  8'hbe
`define SNR_OP4_DTR_QIO  8'hee
// ----------------------------------------------------------------
// Protocol codes, line counts as log2, and counts
// ----------------------------------------------------------------
`define SNR_PROTO_EXT    2'h0
`define SNR_PROTO_DUAL   2'h1
`define SNR_PROTO_QUAD   2'h2
`define SNR_LG1          2'h0
`define SNR_LG2          2'h1
`define SNR_LG4          2'h2
`define SNR_ABITS3       6'h18
`define SNR_ABITS4       6'h20
`define SNR_CMD_BITS     6'h08
`define SNR_QWORD_DUMMY  5'h04
`define SNR_BYTE_BITS    4'h8
`define SNR_FIFO_DEPTH   8
`endif

//--- hw/snr_fifo.sv
// Parameterised valid/ready FIFO between the array fetch and the output shifter.
`timescale 1ns/100ps
module snr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;

  // One extra pointer bit tells full from empty.
  assign in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem[rp_r[AW-1:0]];

  // Pointer advance; a clear drops everything still queued.
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (clear) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (in_valid && in_ready) wp_nxt = wp_r + 1'b1;
      if (out_valid && out_ready) rp_nxt = rp_r + 1'b1;
    end
  end

  // Pointer and storage registers.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (in_valid && in_ready && !clear) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule

//--- hw/snr_pkg.sv
// Types shared by the serial NOR read sequencer.
package snr_pkg;
  // Decoded read command, carried from opcode decode to the data phase.
  typedef struct packed {
    logic [7:0] op;
    logic       ok;
    logic [1:0] alog;
    logic [1:0] dlog;
    logic       dtr;
    logic [5:0] nbits;
    logic [4:0] ndum;
  } snr_cmd_t;

  // Phases of one selection of the device.
  typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP} snr_state_t;
endpackage

//--- hw/snr_read.sv
// Read-memory command sequencer of a multi-line serial NOR flash, device side.
// Function
// - Deselect during data ends the read; device stops driving and abandons it.
// - Non-4-byte read opcodes default to 24-bit address A23..A0.
// - Data starts at the given address and wraps to zero at the boundary.
// - Address bits are sampled on rising serial clock edges, and on both edges at double rate.
// - Any start address; address advances by one per byte fetched into the queue.
// - 03h plain read, 0Bh fast read, 3Bh dual-output fast read.
// - BBh dual I/O, 6Bh quad output, EBh quad I/O.
// - 0Dh, 3Dh, BDh, 6Dh, EDh are double-rate single/dual/quad variants.
// - Double-rate opcodes always run double-rate; others only when enabled.
// - E7h needs even address; exactly four dummy clocks before data.
// - E7h works in extended and quad single-rate; ignored in dual or double-rate.
// - Four-byte reads take a 32-bit address A31..A0.
// - 13h plain read, 0Ch fast read, 3Ch dual-output, all four-byte.
// - BCh dual I/O, 6Ch quad output, ECh quad I/O, all four-byte.
// - 0Eh, BEh, EEh are double-rate four-byte single, dual I/O, quad I/O.
// - Address width comes from nonvolatile setting or enter/exit mode commands.
// - Four-byte opcodes fix their address width; double-rate opcodes fix their rate; others follow configuration.
// - Address ends at clock 7+bits, 3+bits/2 or 1+bits/4 by protocol.
// - Extended dual I/O takes two bits per clock, quad I/O four.
// - In four-byte mode the three-byte read opcodes take four address bytes.
// - Fast read dummy clock count follows a software-set configuration value.
`timescale 1ns/100ps
`include "snr_defs.svh"
module snr_read import snr_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  dq_in,
  output logic      [3:0]  dq_out,
  output logic      [3:0]  dq_oe_n,
  input  wire logic [1:0]  cfg_proto,
  input  wire logic        cfg_dtr,
  input  wire logic        cfg_nv_addr4,
  input  wire logic        cfg_addr4_mode,
  input  wire logic [4:0]  cfg_dummy,
  output logic             read_active,
  output logic             rd_start,
  output logic      [31:0] rd_addr,
  input  wire logic        rd_valid,
  output logic             rd_ready,
  input  wire logic [7:0]  rd_data
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] step(input logic [1:0] lg);
    case (lg)
      `SNR_LG2: return 6'h02;
      `SNR_LG4: return 6'h04;
      default:  return 6'h01;
    endcase
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d, input logic [1:0] lg);
    case (lg)
      `SNR_LG2: return {s[29:0], d[1:0]};
      `SNR_LG4: return {s[27:0], d[3:0]};
      default:  return {s[30:0], d[0]};
    endcase
  endfunction

  // Single-line data leaves on the second line, as the host expects it.
  function automatic logic [3:0] emit(input logic [7:0] b, input logic [1:0] lg);
    case (lg)
      `SNR_LG2: return {2'h0, b[7:6]};
      `SNR_LG4: return b[7:4];
      default:  return {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_mask(input logic [1:0] lg);
    case (lg)
      `SNR_LG2: return 4'hc;
      `SNR_LG4: return 4'h0;
      default:  return 4'hd;
    endcase
  endfunction

  // Opcode decode into line widths, rate, address width and dummy count.
  function automatic snr_cmd_t decode(input logic [7:0] op, input logic [1:0] pr, input logic dtr_en,
                                      input logic a4_en, input logic [4:0] dum);
    snr_cmd_t c;
    c       = '0;
    c.op    = op;
    c.ok    = 1'b1;
    c.alog  = pr;
    c.dlog  = pr;
    c.dtr   = dtr_en;
    c.nbits = a4_en ? `SNR_ABITS4 : `SNR_ABITS3;
    c.ndum  = dum;
    case (op)
      `SNR_OP_READ, `SNR_OP4_READ: c.ndum = 5'h00;
      `SNR_OP_FAST, `SNR_OP4_FAST, `SNR_OP_DTR_FAST, `SNR_OP4_DTR_FAST: ;
      `SNR_OP_DOUT, `SNR_OP4_DOUT, `SNR_OP_DTR_DOUT: begin
        c.dlog = `SNR_LG2;
        c.ok   = pr != `SNR_PROTO_QUAD;
      end
      `SNR_OP_DIO, `SNR_OP4_DIO, `SNR_OP_DTR_DIO, `SNR_OP4_DTR_DIO: begin
        c.alog = `SNR_LG2;
        c.dlog = `SNR_LG2;
        c.ok   = pr != `SNR_PROTO_QUAD;
      end
      `SNR_OP_QOUT, `SNR_OP4_QOUT, `SNR_OP_DTR_QOUT: begin
        c.dlog = `SNR_LG4;
        c.ok   = pr != `SNR_PROTO_DUAL;
      end
      `SNR_OP_QIO, `SNR_OP4_QIO, `SNR_OP_DTR_QIO, `SNR_OP4_DTR_QIO: begin
        c.alog = `SNR_LG4;
        c.dlog = `SNR_LG4;
        c.ok   = pr != `SNR_PROTO_DUAL;
      end
      `SNR_OP_QWORD: begin
        c.alog = `SNR_LG4;
        c.dlog = `SNR_LG4;
        c.ndum = `SNR_QWORD_DUMMY;
        c.ok   = pr != `SNR_PROTO_DUAL && !dtr_en;
      end
      default: c.ok = 1'b0;
    endcase
    if (op inside {`SNR_OP_DTR_FAST, `SNR_OP_DTR_DOUT, `SNR_OP_DTR_DIO, `SNR_OP_DTR_QOUT, `SNR_OP_DTR_QIO,
                   `SNR_OP4_DTR_FAST, `SNR_OP4_DTR_DIO, `SNR_OP4_DTR_QIO})
      c.dtr = 1'b1;
    if (op inside {`SNR_OP4_READ, `SNR_OP4_FAST, `SNR_OP4_DOUT, `SNR_OP4_DIO, `SNR_OP4_QOUT, `SNR_OP4_QIO,
                   `SNR_OP4_DTR_FAST, `SNR_OP4_DTR_DIO, `SNR_OP4_DTR_QIO})
      c.nbits = `SNR_ABITS4;
    return c;
  endfunction

  // Address advance that wraps inside the active address range.
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic a4);
    if (a4) return a + 32'h0000_0001;
    return {8'h00, a[23:0] + 24'h00_0001};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and serial clock edge detection
  // ----------------------------------------------------------------
  logic       sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2;
  logic [3:0] dq_s1, dq_s2;
  logic       sclk_rise, sclk_fall;

  // Clock, select and data share one delay so data is sampled with its edge.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2}              <= 2'h3;
      {dq_s1, dq_s2}              <= 8'h00;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
      {cs_s1, cs_s2}              <= {cs_n, cs_s1};
      {dq_s1, dq_s2}              <= {dq_in, dq_s1};
    end
  end

  assign sclk_rise = sclk_s2 && !sclk_s3;
  assign sclk_fall = !sclk_s2 && sclk_s3;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  snr_state_t  st_r, st_nxt;
  snr_cmd_t    cmd_r, cmd_nxt;
  logic [31:0] sh_r, sh_nxt, addr_r, addr_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [7:0]  osh_r, osh_nxt;
  logic [3:0]  oleft_r, oleft_nxt, dq_r, dq_nxt, oe_r, oe_nxt;
  logic        start_r, start_nxt, fetch_r, fetch_nxt, pop;
  logic        f_ivalid, f_iready, f_ovalid;
  logic [7:0]  f_odata;

  // Next phase, shifters and pin drive for each synchronised serial clock edge.
  always_comb begin
    logic [5:0] n;
    n         = 6'h00;
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    osh_nxt   = osh_r;
    oleft_nxt = oleft_r;
    dq_nxt    = dq_r;
    oe_nxt    = oe_r;
    addr_nxt  = addr_r;
    start_nxt = 1'b0;
    fetch_nxt = fetch_r;
    pop       = 1'b0;
    if (cs_s2) begin
      st_nxt    = S_CMD;
      oe_nxt    = 4'hf;
      fetch_nxt = 1'b0;
      cnt_nxt   = 6'h00;
      oleft_nxt = 4'h0;
    end else begin
      case (st_r)
        S_CMD: if (sclk_rise || (sclk_fall && cfg_dtr)) begin
          sh_nxt  = shift_in(sh_r, dq_s2, cfg_proto);
          cnt_nxt = cnt_r + step(cfg_proto);
          if (cnt_nxt >= `SNR_CMD_BITS) begin
            cmd_nxt = decode(sh_nxt[7:0], cfg_proto, cfg_dtr, cfg_nv_addr4 || cfg_addr4_mode, cfg_dummy);
            cnt_nxt = 6'h00;
            st_nxt  = cmd_nxt.ok ? S_ADDR : S_SKIP;
          end
        end
        S_ADDR: if (sclk_rise || (sclk_fall && cmd_r.dtr)) begin
          sh_nxt  = shift_in(sh_r, dq_s2, cmd_r.alog);
          cnt_nxt = cnt_r + step(cmd_r.alog);
          if (cnt_nxt == cmd_r.nbits) begin
            addr_nxt  = cmd_r.nbits == `SNR_ABITS4 ? sh_nxt : {8'h00, sh_nxt[23:0]};
            start_nxt = 1'b1;
            fetch_nxt = 1'b1;
            cnt_nxt   = 6'h00;
            st_nxt    = cmd_r.ndum == 5'h00 ? S_DATA : S_DUMMY;
          end
        end
        S_DUMMY: if (sclk_rise) begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_nxt == {1'b0, cmd_r.ndum}) st_nxt = S_DATA;
        end
        S_DATA: if (sclk_fall || (sclk_rise && cmd_r.dtr)) begin
          n = step(cmd_r.dlog);
          // An empty queue at a byte edge holds the lines at zero; the fetch
          // side is expected to stay well ahead of the serial clock.
          if (oleft_r == 4'h0 && f_ovalid) begin
            pop       = 1'b1;
            osh_nxt   = f_odata;
            oleft_nxt = `SNR_BYTE_BITS;
          end
          dq_nxt = emit(osh_nxt, cmd_r.dlog);
          oe_nxt = oe_mask(cmd_r.dlog);
          if (oleft_nxt != 4'h0) begin
            osh_nxt   = osh_nxt << n;
            oleft_nxt = oleft_nxt - n[3:0];
          end
        end
        S_SKIP: ;
        default: st_nxt = S_CMD;
      endcase
    end
    if (rd_valid && rd_ready) addr_nxt = next_addr(addr_r, cmd_r.nbits == `SNR_ABITS4);
  end

  // Sequencer registers.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r    <= S_CMD;
      cmd_r   <= '0;
      sh_r    <= 32'h0000_0000;
      cnt_r   <= 6'h00;
      osh_r   <= 8'h00;
      oleft_r <= 4'h0;
      dq_r    <= 4'h0;
      oe_r    <= 4'hf;
      addr_r  <= 32'h0000_0000;
      start_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cmd_r   <= cmd_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      osh_r   <= osh_nxt;
      oleft_r <= oleft_nxt;
      dq_r    <= dq_nxt;
      oe_r    <= oe_nxt;
      addr_r  <= addr_nxt;
      start_r <= start_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // Fetch stalls when the queue is full; a deselect flushes it.
  assign f_ivalid    = rd_valid && fetch_r && !cs_s2;
  assign rd_ready    = fetch_r && f_iready && !cs_s2;
  assign dq_out      = dq_r;
  assign dq_oe_n     = oe_r;
  assign rd_addr     = addr_r;
  assign rd_start    = start_r;
  assign read_active = st_r != S_CMD;

  snr_fifo #(.W(8), .D(`SNR_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clear     (cs_s2),
    .in_valid  (f_ivalid),
    .in_ready  (f_iready),
    .in_data   (rd_data),
    .out_valid (f_ovalid),
    .out_ready (pop),
    .out_data  (f_odata)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_abort_seen;
    cs_s2 && st_r != S_CMD;
  endsequence
  sequence s_quiet;
    st_r == S_CMD && dq_oe_n == 4'hf && !rd_ready;
  endsequence
  sequence s_addr_done;
    st_r == S_ADDR ##1 rd_start;
  endsequence

  property p_abort;
    s_abort_seen |=> s_quiet;
  endproperty
  a_abort: assert property (p_abort) else $error("read not abandoned on deselect");
  property p_hiz_addr;
    st_r inside {S_ADDR, S_DUMMY} |-> dq_oe_n == 4'hf;
  endproperty
  a_hiz_addr: assert property (p_hiz_addr) else $error("lines driven before data");
  property p_start;
    s_addr_done |-> st_r inside {S_DUMMY, S_DATA} && cnt_r == 6'h00;
  endproperty
  a_start: assert property (p_start) else $error("address end did not start data");
  property p_plain;
    st_r == S_ADDR && cmd_r.op inside {`SNR_OP_READ, `SNR_OP4_READ} |-> cmd_r.ndum == 5'h00;
  endproperty
  a_plain: assert property (p_plain) else $error("plain read has dummies");
  property p_qword;
    st_r == S_ADDR && cmd_r.op == `SNR_OP_QWORD |-> cmd_r.ndum == `SNR_QWORD_DUMMY && cmd_r.alog == `SNR_LG4;
  endproperty
  a_qword: assert property (p_qword) else $error("word read dummy count wrong");
  property p_qword_mode;
    st_r == S_ADDR && cmd_r.op == `SNR_OP_QWORD |-> cfg_proto != `SNR_PROTO_DUAL && !cfg_dtr;
  endproperty
  a_qword_mode: assert property (p_qword_mode) else $error("word read accepted in bad mode");
  property p_dtr_fixed;
    st_r == S_ADDR && cmd_r.op inside {`SNR_OP_DTR_FAST, `SNR_OP_DTR_QIO, `SNR_OP4_DTR_DIO} |-> cmd_r.dtr;
  endproperty
  a_dtr_fixed: assert property (p_dtr_fixed) else $error("double-rate opcode at single rate");
  property p_a4_fixed;
    st_r == S_ADDR && cmd_r.op inside {`SNR_OP4_READ, `SNR_OP4_QIO} |-> cmd_r.nbits == `SNR_ABITS4;
  endproperty
  a_a4_fixed: assert property (p_a4_fixed) else $error("four-byte opcode not 32-bit");
  property p_a3_default;
    st_r == S_ADDR && cmd_r.op == `SNR_OP_READ && !cfg_nv_addr4 && !cfg_addr4_mode |-> cmd_r.nbits == `SNR_ABITS3;
  endproperty
  a_a3_default: assert property (p_a3_default) else $error("default address not 24-bit");
  property p_inc;
    rd_valid && rd_ready && cmd_r.nbits == `SNR_ABITS4 |=> rd_addr == $past(rd_addr) + 32'h0000_0001;
  endproperty
  a_inc: assert property (p_inc) else $error("address did not advance");
  property p_dummy;
    st_r == S_DUMMY && !cs_s2 && sclk_rise && cnt_r + 6'h01 == {1'b0, cmd_r.ndum} |=> st_r == S_DATA;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy count not honoured");
endmodule

//--- verification/snr_host_model.sv
// Behavioural host controller that clocks read frames into the sequencer.
`timescale 1ns/100ps
module snr_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] dq_out,
  input  wire logic [3:0] dq_oe_n,
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] host_dq
);
  logic [7:0] rx [0:31];
  int         nrx;
  logic [3:0] oe_first;
  logic [3:0] oe_dum;
  logic       ddr_op = 1'b0;  // Opcode moves on both serial clock edges.
  logic       ddr    = 1'b0;  // Address and data move on both serial clock edges.

  // ----------------------------------------------------------------
  // Idle: deselected, clock parked low between frames.
  // ----------------------------------------------------------------
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    host_dq = 4'h0;
  end

  // One half period of the 160 ns serial clock.
  task automatic half(input logic lvl);
    sclk = lvl;
    repeat (4) @(negedge mclk);
  endtask

  // Shift MSB first; spare lines toggle so that no stale level survives.
  // At double rate each edge takes one unit, set half a phase ahead of it.
  task automatic send(input logic [31:0] v, input int nb, input int lg, input logic dd);
    for (int i = nb - (1 << lg); i >= 0; i -= (1 << lg)) begin
      host_dq = ~host_dq;
      for (int k = 0; k < (1 << lg); k++) host_dq[k] = v[i + k];
      if (dd) begin
        repeat (2) @(negedge mclk);
        sclk = ~sclk;
        repeat (2) @(negedge mclk);
      end else begin
        half(1'b0);
        half(1'b1);
      end
    end
  endtask

  // Whole frame; data is sampled late in the high phase at single rate and late in each phase at double rate, well after the device's output edge.
  task automatic xfer(input logic [7:0] op, input int olg, input int alg, input int dlg, input int abits,
                      input logic [31:0] addr, input int ndum, input int nclk, input int stall);
    logic [7:0] sh;
    int         got;
    sh   = 8'h00;
    got  = 0;
    nrx  = 0;
    cs_n = 1'b0;
    half(1'b0);
    send({24'h0, op}, 8, olg, ddr_op);
    send(addr, abits, alg, ddr);
    host_dq = ~host_dq;
    repeat (ndum) begin
      half(1'b0);
      half(1'b1);
    end
    oe_dum = dq_oe_n;
    repeat (stall) @(negedge mclk);
    for (int c = 0; c < nclk; c++) begin
      if (ddr) half(~sclk);
      else begin
        half(1'b0);
        half(1'b1);
      end
      host_dq = ~host_dq;
      if (c == 0) oe_first = dq_oe_n;
      case (dlg)
        0: sh = {sh[6:0], dq_out[1]};
        1: sh = {sh[5:0], dq_out[1:0]};
        default: sh = {sh[3:0], dq_out};
      endcase
      got += 1 << dlg;
      if (got == 8) begin
        rx[nrx] = sh;
        nrx++;
        got = 0;
      end
    end
    sclk = 1'b0;
    cs_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
endmodule

//--- verification/test_serial_nor_read_memory.sv
// Self-checking bench of the read sequencer against a host model and an array model.
`timescale 1ns/100ps
`include "snr_defs.svh"
module test_serial_nor_read_memory import snr_pkg::*;;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sclk, cs_n, read_active, rd_start, rd_ready;
  logic [3:0]  host_dq, dq_in, dq_out, dq_oe_n;
  logic [1:0]  cfg_proto = `SNR_PROTO_EXT;
  logic        cfg_dtr = 1'b0;
  logic        cfg_nv_addr4 = 1'b0;
  logic        cfg_addr4_mode = 1'b0;
  logic [4:0]  cfg_dummy = 5'h08;
  logic [31:0] rd_addr, start_addr, a;
  logic        rd_valid = 1'b0;
  logic [7:0]  rd_data = 8'h00;
  int          seed, fails, comparisons, starts, accepts, drove, nd, ab;
  logic [7:0]  ops [0:12] = '{`SNR_OP_READ, `SNR_OP_FAST, `SNR_OP_DOUT, `SNR_OP_DIO, `SNR_OP_QOUT, `SNR_OP_QIO,
                              `SNR_OP_QWORD, `SNR_OP4_READ, `SNR_OP4_FAST, `SNR_OP4_DOUT, `SNR_OP4_DIO,
                              `SNR_OP4_QOUT, `SNR_OP4_QIO};
  int          al [0:12] = '{0, 0, 0, 1, 0, 2, 2, 0, 0, 0, 1, 0, 2};
  int          dl [0:12] = '{0, 0, 1, 1, 2, 2, 2, 0, 0, 1, 1, 2, 2};
  int          kd [0:12] = '{0, 1, 1, 1, 1, 1, 2, 0, 1, 1, 1, 1, 1};

  // ----------------------------------------------------------------
  // Clock, wire resolution, design and host.
  // ----------------------------------------------------------------
  initial begin
    forever #10 mclk = ~mclk;
  end

  // A line reads the device's value only where its enable is low.
  assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & host_dq);

  snr_read uut (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
                .dq_oe_n(dq_oe_n), .cfg_proto(cfg_proto), .cfg_dtr(cfg_dtr), .cfg_nv_addr4(cfg_nv_addr4),
                .cfg_addr4_mode(cfg_addr4_mode), .cfg_dummy(cfg_dummy), .read_active(read_active),
                .rd_start(rd_start), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_ready(rd_ready),
                .rd_data(rd_data));

  snr_host_model u_host (.mclk(mclk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .sclk(sclk), .cs_n(cs_n),
                         .host_dq(host_dq));

  // ----------------------------------------------------------------
  // Array model and monitors.
  // ----------------------------------------------------------------
  function automatic logic [7:0] mem_byte(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ x[31:24] ^ 8'h5a;
  endfunction

  // Random valid gaps make the fetch side stall now and then; never two in a row,
  // so the array keeps ahead of the first output edge as the design expects.
  always @(negedge mclk) begin
    rd_valid <= (($random(seed) & 3) != 0) || !rd_valid;
    rd_data  <= mem_byte(rd_addr);
  end

  // Count starts, accepted bytes and cycles with any line driven.
  always @(posedge mclk) begin
    if (rd_start === 1'b1) begin
      starts++;
      start_addr = rd_addr;
    end
    if (rd_valid && rd_ready === 1'b1) accepts++;
    if (dq_oe_n !== 4'hf) drove++;
  end

  // ----------------------------------------------------------------
  // Checking tasks.
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One read frame; three-byte addresses wrap inside 24 bits.
  task automatic rd(input logic [7:0] op, input int olg, input int alg, input int dlg, input int abits,
                    input logic [31:0] x, input int ndum, input int nby, input int stall);
    logic [31:0] mk;
    mk     = (abits == 24) ? 32'h00ff_ffff : 32'hffff_ffff;
    starts = 0;
    u_host.xfer(op, olg, alg, dlg, abits, x, ndum, nby * 8, stall);
    chk("start count", 32'h1, 32'(starts));
    chk("start address", x & mk, start_addr);
    chk("enables before data", 32'hf, 32'(u_host.oe_dum));
    chk("data enables", (dlg == 0) ? 32'hd : (dlg == 1) ? 32'hc : 32'h0, 32'(u_host.oe_first));
    for (int i = 0; i < nby; i++) chk("data byte", 32'(mem_byte((x + i) & mk)), 32'(u_host.rx[i]));
    chk("released", 32'hf, 32'(dq_oe_n));
    chk("active", 32'h0, 32'(read_active));
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 12500 cycles.
  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h51e8_33d5;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk("reset enables", 32'hf, 32'(dq_oe_n));
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 13; i++) begin
      a = $random(seed);
      if (ops[i] == `SNR_OP_QWORD) a[0] = 1'b0;
      ab = (i > 6) ? 32 : 24;
      cfg_dummy = 5'(($random(seed) & 7) + 2);
      nd = (kd[i] == 0) ? 0 : (kd[i] == 2) ? 4 : int'(cfg_dummy);
      rd(ops[i], 0, al[i], dl[i], ab, a, nd, 4, 0);
    end
    rd(`SNR_OP_READ, 0, 0, 0, 24, 32'h00ff_fffe, 0, 4, 0);
    cfg_addr4_mode = 1'b1;
    rd(`SNR_OP_FAST, 0, 0, 0, 32, 32'hff00_0003, int'(cfg_dummy), 3, 0);
    cfg_addr4_mode = 1'b0;
    cfg_nv_addr4 = 1'b1;
    rd(`SNR_OP_READ, 0, 0, 0, 32, 32'h8000_0001, 0, 3, 0);
    cfg_nv_addr4 = 1'b0;
    cfg_proto = `SNR_PROTO_QUAD;
    rd(`SNR_OP_QIO, 2, 2, 2, 24, 32'h0012_3456, int'(cfg_dummy), 4, 0);
    cfg_proto = `SNR_PROTO_DUAL;
    rd(`SNR_OP_DIO, 1, 1, 1, 24, 32'h0065_4321, int'(cfg_dummy), 4, 0);
    starts = 0;
    drove = 0;
    u_host.xfer(`SNR_OP_QWORD, 1, 1, 1, 24, 32'h0000_0010, 4, 16, 0);
    chk("ignored start", 32'h0, 32'(starts));
    chk("ignored drive", 32'h0, 32'(drove));
    cfg_proto = `SNR_PROTO_EXT;
    u_host.ddr = 1'b1;
    rd(`SNR_OP_DTR_FAST, 0, 0, 0, 24, 32'h0034_5678, int'(cfg_dummy), 4, 0);
    rd(`SNR_OP4_DTR_QIO, 0, 2, 2, 32, 32'h89ab_cdef, int'(cfg_dummy), 4, 0);
    u_host.ddr = 1'b0;
    cfg_dtr = 1'b1;
    u_host.ddr_op = 1'b1;
    starts = 0;
    drove = 0;
    u_host.xfer(`SNR_OP_QWORD, 0, 2, 2, 24, 32'h0000_0020, 4, 8, 0);
    chk("dtr word start", 32'h0, 32'(starts));
    chk("dtr word drive", 32'h0, 32'(drove));
    u_host.ddr_op = 1'b0;
    cfg_dtr = 1'b0;
    u_host.xfer(`SNR_OP_FAST, 0, 0, 0, 24, 32'h0000_0100, int'(cfg_dummy), 13, 0);
    chk("abort enables", 32'hf, 32'(dq_oe_n));
    chk("abort active", 32'h0, 32'(read_active));
    accepts = 0;
    fork
      rd(`SNR_OP_READ, 0, 0, 0, 24, 32'h0000_0200, 0, 16, 300);
      begin
        repeat (400) @(negedge mclk);
        chk("full refuses", 32'h0, 32'(rd_ready));
        chk("full count", 32'h1, 32'(accepts >= `SNR_FIFO_DEPTH));
      end
    join
    end_sim();
  end
endmodule
